// File: hdl/scr_map.svh
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// register select codes in the four lowest word bits
`define SCR_SEL_LSB 0
`define SCR_SEL_MSB 3
`define SCR_CODE_ZERO 4'h0
`define SCR_CODE_FOUR 4'h4
`define SCR_CODE_FIVE 4'h5
`define SCR_CODE_SIX 4'h6
`define SCR_CODE_SEVEN 4'h7

// reference_and_pump_control fields
`define SCR_R4_MUX_MSB 29
`define SCR_R4_MUX_LSB 27
`define SCR_R4_DOUBLER 26
`define SCR_R4_HALF_DIV 25
`define SCR_R4_RDIV_MSB 24
`define SCR_R4_RDIV_LSB 15
`define SCR_R4_DBUF 14
`define SCR_R4_CP_MSB 13
`define SCR_R4_CP_LSB 10
`define SCR_R4_LEVEL 8
`define SCR_R4_POLARITY 7
`define SCR_R4_PDOWN 6
`define SCR_R4_TRISTATE 5
`define SCR_R4_CNT_RST 4

// output_and_bleed_control fields
`define SCR_R6_GATED_BLEED 30
`define SCR_R6_NEG_BLEED 29
`define SCR_R6_FB_SEL 24
`define SCR_R6_DIV_MSB 23
`define SCR_R6_DIV_LSB 21
`define SCR_R6_BLEED_MSB 20
`define SCR_R6_BLEED_LSB 13
`define SCR_R6_MUTE 11
`define SCR_R6_AUX_DIS 10
`define SCR_R6_MAIN_EN 6
`define SCR_R6_PWR_MSB 5
`define SCR_R6_PWR_LSB 4

// lock_detect_control fields
`define SCR_R7_LE_SYNC 25
`define SCR_R7_LDC_MSB 9
`define SCR_R7_LDC_LSB 8
`define SCR_R7_LOL 7
`define SCR_R7_LDP_MSB 6
`define SCR_R7_LDP_LSB 5
`define SCR_R7_LDM 4

// reset values of the stored words
`define SCR_R4_RESET 32'h0000_0000
`define SCR_R6_RESET 32'h0000_0000
`define SCR_R7_RESET 32'h0000_0000
`define SCR_DIV_RESET 3'h0

// lock windows in picoseconds
`define SCR_WIN_5NS 16'h1388
`define SCR_WIN_6NS 16'h1770
`define SCR_WIN_8NS 16'h1f40
`define SCR_WIN_12NS 16'h2ee0
`define SCR_WIN_FIXED 16'h0b54

// consecutive in-window cycles per count code
`define SCR_LDC_0 14'h0040
`define SCR_LDC_1 14'h0080
`define SCR_LDC_2 14'h0100
`define SCR_LDC_3 14'h0200

`endif

// File: hdl/scr_pkg.sv
package scr_pkg;
	// load strobe sequencer, one-hot
	typedef enum logic [2:0] {
		LD_IDLE = 3'b001,
		LD_WAIT = 3'b010,
		LD_APPLY = 3'b100
	} scr_load_t;
endpackage

// File: hdl/scr_ref_path.sv
`timescale 1ns/1ps
// reference edge select, 10-bit divider and optional toggle stage
module scr_ref_path (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ref_in,
	input wire logic doubler_en,
	input wire logic half_div_en,
	input wire logic [9:0] r_div,
	input wire logic hold,
	output logic ref_rise,
	output logic pfd_tick,
	output logic pfd_clk
);
	logic ref_q;
	logic [9:0] cnt;
	logic tgl;
	logic active;
	logic fire;
	logic [9:0] ratio;

	// edge detect on the sampled reference
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_in;
		end
	end
	assign ref_rise = ref_in & ~ref_q;
	// falling edge only, or both edges when doubled
	assign active = doubler_en ? (ref_in ^ ref_q) : (~ref_in & ref_q);
	assign ratio = (r_div == 10'h000) ? 10'h001 : r_div;
	assign fire = active && (cnt + 10'h001 >= ratio);

	// divider and toggle stage, held cleared by hold
	always_ff @(posedge clock) begin
		if (!rst_n || hold) begin
			cnt <= 10'h000;
			tgl <= 1'b0;
			pfd_tick <= 1'b0;
		end else begin
			pfd_tick <= 1'b0;
			if (active) begin
				cnt <= fire ? 10'h000 : cnt + 10'h001;
			end
			if (fire) begin
				tgl <= ~tgl;
				pfd_tick <= half_div_en ? ~tgl : 1'b1;
			end
		end
	end
	assign pfd_clk = half_div_en ? tgl : pfd_tick;

	AST_HALF_TICK: assert property (@(posedge clock) disable iff (!rst_n || hold)
		half_div_en && fire && tgl |=> !pfd_tick)
		else $error("tick issued on falling half of divided clock");
	AST_RATIO: assert property (@(posedge clock) disable iff (!rst_n || hold)
		cnt >= ratio |=> cnt == $past(cnt) || cnt == 10'h000)
		else $error("divider count grew past ratio");
endmodule

// File: hdl/scr_lock_det.sv
`timescale 1ns/1ps
// counts consecutive in-window comparison cycles
module scr_lock_det (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic tick,
	input wire logic [15:0] err_ps,
	input wire logic [15:0] window_ps,
	input wire logic [13:0] target,
	output logic locked
);
	logic [13:0] cnt;

	// restart on any out-of-window cycle
	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			cnt <= 14'h0000;
			locked <= 1'b0;
		end else if (tick) begin
			if (err_ps > window_ps) begin
				cnt <= 14'h0000;
				locked <= 1'b0;
			end else if (cnt + 14'h0001 >= target) begin
				locked <= 1'b1;
			end else begin
				cnt <= cnt + 14'h0001;
			end
		end
	end

	AST_LOCK_COUNT: assert property (@(posedge clock) disable iff (!rst_n || clear)
		$rose(locked) |-> $past(cnt) + 14'h0001 >= $past(target))
		else $error("lock asserted before count reached");
	AST_LOCK_DROP: assert property (@(posedge clock) disable iff (!rst_n || clear)
		tick && err_ps > window_ps |=> !locked && cnt == 14'h0000)
		else $error("lock kept after out-of-window cycle");
endmodule

// File: hdl/scr_top.sv
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_top (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [31:0] WORD_DATA,
	input wire logic LATCH_STROBE,
	input wire logic REF_IN,
	input wire logic [15:0] PHASE_ERROR_PS,
	output logic [2:0] TEST_MUX_OUTPUT,
	output logic MUX_LEVEL_SEL,
	output logic [3:0] PUMP_CURRENT_CODE,
	output logic PFD_POLARITY,
	output logic SOFT_POWERDOWN,
	output logic PUMP_HIGH_Z,
	output logic COUNTER_HOLD,
	output logic PHASE_DETECTOR_CLK,
	output logic PHASE_DETECTOR_TICK,
	output logic FEEDBACK_SELECT,
	output logic [2:0] OUTPUT_DIVIDER_SEL,
	output logic [7:0] BLEED_LEVEL,
	output logic BLEED_ON,
	output logic NEGATIVE_BLEED_ON,
	output logic MAIN_OUT_ON,
	output logic AUX_OUT_ON,
	output logic [1:0] MAIN_OUT_POWER,
	output logic REF_LOSS_MODE,
	output logic [15:0] LOCK_WINDOW_PS,
	output logic LOCK_DETECT,
	output logic LOAD_EVENT
);
	scr_pkg::scr_load_t state;
	scr_pkg::scr_load_t next_state;
	logic [31:0] pend_word;
	logic [31:0] ref_pump;
	logic [31:0] out_bleed;
	logic [31:0] lock_ctl;
	logic [2:0] div_active;
	logic [3:0] sel;
	logic ref_rise;
	logic pfd_tick;
	logic pfd_clk;
	logic locked;
	logic powerdown;
	logic hold;
	logic [13:0] lock_target;
	logic [15:0] window;
	logic apply;
	logic out_gate;

	////////////////////////////////////////////////////////////////
	// load strobe sequencing

	// capture the word as the strobe arrives
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pend_word <= 32'h0000_0000;
		end else if (LATCH_STROBE) begin
			pend_word <= WORD_DATA;
		end
	end

	// wait for a reference rise when sync is on
	always_comb begin
		next_state = state;
		unique case (state)
			scr_pkg::LD_IDLE: begin
				if (LATCH_STROBE) begin
					next_state = lock_ctl[`SCR_R7_LE_SYNC] ? scr_pkg::LD_WAIT
						: scr_pkg::LD_APPLY;
				end
			end
			scr_pkg::LD_WAIT: begin
				if (ref_rise) begin
					next_state = scr_pkg::LD_APPLY;
				end
			end
			scr_pkg::LD_APPLY: begin
				next_state = LATCH_STROBE ? (lock_ctl[`SCR_R7_LE_SYNC] ? scr_pkg::LD_WAIT
					: scr_pkg::LD_APPLY) : scr_pkg::LD_IDLE;
			end
			default: begin
				next_state = scr_pkg::LD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state <= scr_pkg::LD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign apply = (state == scr_pkg::LD_APPLY);
	assign sel = pend_word[`SCR_SEL_MSB:`SCR_SEL_LSB];

	////////////////////////////////////////////////////////////////
	// configuration words

	// route the applied word by its select code
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ref_pump <= `SCR_R4_RESET;
			out_bleed <= `SCR_R6_RESET;
			lock_ctl <= `SCR_R7_RESET;
		end else if (apply) begin
			unique case (sel)
				`SCR_CODE_FOUR: ref_pump <= pend_word;
				`SCR_CODE_SIX: out_bleed <= pend_word;
				`SCR_CODE_SEVEN: lock_ctl <= pend_word;
				default: ;
			endcase
		end
	end

	// divider select, optionally held for the next register-zero write
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			div_active <= `SCR_DIV_RESET;
		end else if (!ref_pump[`SCR_R4_DBUF]) begin
			div_active <= out_bleed[`SCR_R6_DIV_MSB:`SCR_R6_DIV_LSB];
		end else if (apply && sel == `SCR_CODE_ZERO) begin
			div_active <= out_bleed[`SCR_R6_DIV_MSB:`SCR_R6_DIV_LSB];
		end
	end

	////////////////////////////////////////////////////////////////
	// reference path and lock detection

	assign powerdown = ref_pump[`SCR_R4_PDOWN];
	assign hold = powerdown | ref_pump[`SCR_R4_CNT_RST];

	scr_ref_path u_ref (
		.clock(CLOCK),
		.rst_n(RST_N),
		.ref_in(REF_IN),
		.doubler_en(ref_pump[`SCR_R4_DOUBLER]),
		.half_div_en(ref_pump[`SCR_R4_HALF_DIV]),
		.r_div(ref_pump[`SCR_R4_RDIV_MSB:`SCR_R4_RDIV_LSB]),
		.hold(hold),
		.ref_rise(ref_rise),
		.pfd_tick(pfd_tick),
		.pfd_clk(pfd_clk)
	);

	// window from precision code or the fixed integer setting
	always_comb begin
		window = `SCR_WIN_5NS;
		if (lock_ctl[`SCR_R7_LDM]) begin
			window = `SCR_WIN_FIXED;
		end else begin
			unique case (lock_ctl[`SCR_R7_LDP_MSB:`SCR_R7_LDP_LSB])
				2'h0: window = `SCR_WIN_5NS;
				2'h1: window = `SCR_WIN_6NS;
				2'h2: window = `SCR_WIN_8NS;
				2'h3: window = `SCR_WIN_12NS;
			endcase
		end
	end

	// consecutive count per code
	always_comb begin
		lock_target = `SCR_LDC_0;
		unique case (lock_ctl[`SCR_R7_LDC_MSB:`SCR_R7_LDC_LSB])
			2'h0: lock_target = `SCR_LDC_0;
			2'h1: lock_target = `SCR_LDC_1;
			2'h2: lock_target = `SCR_LDC_2;
			2'h3: lock_target = `SCR_LDC_3;
		endcase
	end

	scr_lock_det u_lock (
		.clock(CLOCK),
		.rst_n(RST_N),
		.clear(hold),
		.tick(pfd_tick),
		.err_ps(PHASE_ERROR_PS),
		.window_ps(window),
		.target(lock_target),
		.locked(locked)
	);

	////////////////////////////////////////////////////////////////
	// registered control outputs

	// outputs muted until lock when asked to
	assign out_gate = !powerdown && !(out_bleed[`SCR_R6_MUTE] && !locked);

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			TEST_MUX_OUTPUT <= 3'h0;
			MUX_LEVEL_SEL <= 1'b0;
			PUMP_CURRENT_CODE <= 4'h0;
			PFD_POLARITY <= 1'b0;
			SOFT_POWERDOWN <= 1'b0;
			PUMP_HIGH_Z <= 1'b0;
			COUNTER_HOLD <= 1'b0;
			FEEDBACK_SELECT <= 1'b0;
			OUTPUT_DIVIDER_SEL <= 3'h0;
			BLEED_LEVEL <= 8'h00;
			BLEED_ON <= 1'b0;
			NEGATIVE_BLEED_ON <= 1'b0;
			MAIN_OUT_ON <= 1'b0;
			AUX_OUT_ON <= 1'b0;
			MAIN_OUT_POWER <= 2'h0;
			REF_LOSS_MODE <= 1'b0;
			LOCK_WINDOW_PS <= 16'h0000;
			LOCK_DETECT <= 1'b0;
			LOAD_EVENT <= 1'b0;
		end else begin
			TEST_MUX_OUTPUT <= ref_pump[`SCR_R4_MUX_MSB:`SCR_R4_MUX_LSB];
			MUX_LEVEL_SEL <= ref_pump[`SCR_R4_LEVEL];
			PUMP_CURRENT_CODE <= ref_pump[`SCR_R4_CP_MSB:`SCR_R4_CP_LSB];
			PFD_POLARITY <= ref_pump[`SCR_R4_POLARITY];
			SOFT_POWERDOWN <= powerdown;
			PUMP_HIGH_Z <= ref_pump[`SCR_R4_TRISTATE] | powerdown;
			COUNTER_HOLD <= hold;
			FEEDBACK_SELECT <= out_bleed[`SCR_R6_FB_SEL];
			OUTPUT_DIVIDER_SEL <= div_active;
			BLEED_LEVEL <= out_bleed[`SCR_R6_BLEED_MSB:`SCR_R6_BLEED_LSB];
			BLEED_ON <= !powerdown && (!out_bleed[`SCR_R6_GATED_BLEED] || locked);
			NEGATIVE_BLEED_ON <= out_bleed[`SCR_R6_NEG_BLEED] && !powerdown
				&& (!out_bleed[`SCR_R6_GATED_BLEED] || locked);
			MAIN_OUT_ON <= out_bleed[`SCR_R6_MAIN_EN] && out_gate;
			AUX_OUT_ON <= !out_bleed[`SCR_R6_AUX_DIS] && out_gate;
			MAIN_OUT_POWER <= out_bleed[`SCR_R6_PWR_MSB:`SCR_R6_PWR_LSB];
			REF_LOSS_MODE <= lock_ctl[`SCR_R7_LOL];
			LOCK_WINDOW_PS <= window;
			LOCK_DETECT <= locked && !hold;
			LOAD_EVENT <= apply;
		end
	end

	assign PHASE_DETECTOR_CLK = pfd_clk;
	assign PHASE_DETECTOR_TICK = pfd_tick;

	////////////////////////////////////////////////////////////////
	// checks

	AST_ROUTE_FOUR: assert property (@(posedge CLOCK) disable iff (!RST_N)
		apply && sel == `SCR_CODE_FOUR |=> ref_pump == $past(pend_word))
		else $error("code four word not stored");
	AST_ROUTE_OTHER: assert property (@(posedge CLOCK) disable iff (!RST_N)
		apply && sel == `SCR_CODE_FIVE |=> $stable(ref_pump) && $stable(out_bleed)
		&& $stable(lock_ctl))
		else $error("reserved word altered a register");
	AST_DBUF_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_N)
		ref_pump[`SCR_R4_DBUF] && !(apply && sel == `SCR_CODE_ZERO) |=> $stable(div_active))
		else $error("buffered divider select changed without register zero");
	AST_PDOWN_EFFECTS: assert property (@(posedge CLOCK) disable iff (!RST_N)
		powerdown && $stable(powerdown) |=> PUMP_HIGH_Z && COUNTER_HOLD && !MAIN_OUT_ON
		&& !AUX_OUT_ON && !LOCK_DETECT)
		else $error("power-down effects missing");
	AST_PDOWN_KEEPS: assert property (@(posedge CLOCK) disable iff (!RST_N)
		powerdown && !apply |=> $stable(out_bleed) && $stable(lock_ctl))
		else $error("register lost during power-down");
	AST_GATED_BLEED: assert property (@(posedge CLOCK) disable iff (!RST_N)
		out_bleed[`SCR_R6_GATED_BLEED] && !locked |=> !BLEED_ON)
		else $error("bleed on before lock");
	AST_MUTE: assert property (@(posedge CLOCK) disable iff (!RST_N)
		out_bleed[`SCR_R6_MUTE] && !locked |=> !MAIN_OUT_ON && !AUX_OUT_ON)
		else $error("output on before lock while muted");
	AST_SYNC_WAIT: assert property (@(posedge CLOCK) disable iff (!RST_N)
		state == scr_pkg::LD_WAIT && !ref_rise |=> !apply)
		else $error("synced load applied without reference rise");
	AST_FIXED_WIN: assert property (@(posedge CLOCK) disable iff (!RST_N)
		lock_ctl[`SCR_R7_LDM] |=> LOCK_WINDOW_PS == `SCR_WIN_FIXED)
		else $error("fixed window not selected");
endmodule

// File: tb/scr_host.sv
`timescale 1ns/1ps
// host side: delivers finished words and runs the reference source
module scr_host (
	input wire logic clock,
	input wire logic load_event,
	output logic [31:0] word_data,
	output logic latch_strobe,
	output logic ref_in
);
	logic ref_run = 1'b0;
	logic ld_seen = 1'b0;
	int cnt = 0;
	initial begin
		word_data = 32'h0000_0000;
		latch_strobe = 1'b0;
		ref_in = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// reference source, four clocks per level, frozen while stopped
	always @(posedge clock) begin
		#1;
		if (ref_run) begin
			cnt = (cnt + 1) % 4;
			if (cnt == 0) ref_in = ~ref_in;
		end
	end
	// one word per strobe, spaced as the load walk needs
	task automatic send(input logic [31:0] w);
		@(posedge clock);
		#1;
		word_data = w;
		latch_strobe = 1'b1;
		@(posedge clock);
		#1;
		latch_strobe = 1'b0;
		word_data = ~w; // data no longer valid
		@(posedge clock);
		#1;
		ld_seen = load_event;
		@(posedge clock);
		@(posedge clock);
		#1;
	endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
// host writes words, decoded outputs compared against field values
module testbench;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic [15:0] PHASE_ERROR_PS = 16'h0064;
	logic [31:0] WORD_DATA;
	logic LATCH_STROBE, REF_IN, MUX_LEVEL_SEL, PFD_POLARITY, SOFT_POWERDOWN, PUMP_HIGH_Z;
	logic COUNTER_HOLD, PHASE_DETECTOR_CLK, PHASE_DETECTOR_TICK, FEEDBACK_SELECT, BLEED_ON;
	logic NEGATIVE_BLEED_ON, MAIN_OUT_ON, AUX_OUT_ON, REF_LOSS_MODE, LOCK_DETECT, LOAD_EVENT;
	logic [2:0] TEST_MUX_OUTPUT, OUTPUT_DIVIDER_SEL;
	logic [3:0] PUMP_CURRENT_CODE;
	logic [7:0] BLEED_LEVEL;
	logic [1:0] MAIN_OUT_POWER;
	logic [15:0] LOCK_WINDOW_PS;
	logic [2:0] ctl [3] = '{3'b001, 3'b010, 3'b111};
	logic dbl [6] = '{0, 0, 1, 0, 1, 0};
	logic hlf [6] = '{0, 0, 0, 1, 1, 0};
	logic [9:0] rr [6] = '{1, 3, 3, 3, 1, 3};
	int ex [6] = '{60, 20, 40, 10, 60, 0};
	logic [15:0] win [5] = '{16'h1388, 16'h1770, 16'h1f40, 16'h2ee0, 16'h0b54};
	int num_errors = 0;
	int checked = 0;
	int n;
	int c;
	int i;
	int m;
	logic pc;
	////////////////////////////////////////////////////////////////////////////////
	// clock and instances
	always #25 CLOCK = ~CLOCK;
	scr_host host (.clock(CLOCK), .load_event(LOAD_EVENT), .word_data(WORD_DATA),
		.latch_strobe(LATCH_STROBE), .ref_in(REF_IN));
	scr_top uut (.CLOCK(CLOCK), .RST_N(RST_N), .WORD_DATA(WORD_DATA),
		.LATCH_STROBE(LATCH_STROBE), .REF_IN(REF_IN), .PHASE_ERROR_PS(PHASE_ERROR_PS),
		.TEST_MUX_OUTPUT(TEST_MUX_OUTPUT), .MUX_LEVEL_SEL(MUX_LEVEL_SEL),
		.PUMP_CURRENT_CODE(PUMP_CURRENT_CODE), .PFD_POLARITY(PFD_POLARITY),
		.SOFT_POWERDOWN(SOFT_POWERDOWN), .PUMP_HIGH_Z(PUMP_HIGH_Z), .COUNTER_HOLD(COUNTER_HOLD),
		.PHASE_DETECTOR_CLK(PHASE_DETECTOR_CLK), .PHASE_DETECTOR_TICK(PHASE_DETECTOR_TICK),
		.FEEDBACK_SELECT(FEEDBACK_SELECT), .OUTPUT_DIVIDER_SEL(OUTPUT_DIVIDER_SEL),
		.BLEED_LEVEL(BLEED_LEVEL), .BLEED_ON(BLEED_ON), .NEGATIVE_BLEED_ON(NEGATIVE_BLEED_ON),
		.MAIN_OUT_ON(MAIN_OUT_ON), .AUX_OUT_ON(AUX_OUT_ON), .MAIN_OUT_POWER(MAIN_OUT_POWER),
		.REF_LOSS_MODE(REF_LOSS_MODE), .LOCK_WINDOW_PS(LOCK_WINDOW_PS),
		.LOCK_DETECT(LOCK_DETECT), .LOAD_EVENT(LOAD_EVENT));
	////////////////////////////////////////////////////////////////////////////////
	// word builders
	function automatic logic [31:0] w4(input logic d, h, input logic [9:0] r, input logic b,
		input logic [3:0] cp, input logic [3:0] u);
		return {2'h0, 3'h5, d, h, r, b, cp, 1'b0, 1'b1, u, 4'h4};
	endfunction
	function automatic logic [31:0] w6(input logic g, ng, fb, input logic [2:0] dv,
		input logic mu, ad, me, input logic [1:0] pw);
		return {1'b0, g, ng, 1'b1, 3'h2, fb, dv, 8'ha5, 1'b0, mu, ad, 3'h0, me, pw, 4'h6};
	endfunction
	function automatic logic [31:0] w7(input logic s, input logic [1:0] lc, input logic ll,
		input logic [1:0] lp, input logic lm);
		return {3'h0, 1'b1, 2'h0, s, 15'h0, lc, ll, lp, lm, 4'h7};
	endfunction
	// compare, hang and verdict
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic hang;
		num_errors++;
		$display("[FAIL] %0t ns: wait ran out", $time);
		test_done;
	endtask
	task automatic ticks(input int cyc);
		n = 0;
		m = 0;
		pc = PHASE_DETECTOR_CLK;
		repeat (cyc) begin
			@(posedge CLOCK);
			#1;
			if (PHASE_DETECTOR_TICK === 1'b1) n++;
			if (PHASE_DETECTOR_CLK === 1'b1 && pc === 1'b0) m++;
			pc = PHASE_DETECTOR_CLK;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge CLOCK);
		#1;
		chk({PUMP_CURRENT_CODE, MAIN_OUT_ON, BLEED_ON, LOCK_WINDOW_PS[7:0]}, 20'h0);
		RST_N = 1'b1;
		@(posedge CLOCK);
		#1;
		chk({PUMP_CURRENT_CODE, MAIN_OUT_ON, BLEED_ON, LOCK_WINDOW_PS[7:0]}, 20'h00188);
		$display("test reset done");
		host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h8));
		chk({TEST_MUX_OUTPUT, MUX_LEVEL_SEL, PUMP_CURRENT_CODE, PFD_POLARITY}, 9'h175);
		chk(host.ld_seen, 1'b1);
		for (i = 0; i < 3; i++) begin
			host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h1 << i));
			chk({SOFT_POWERDOWN, PUMP_HIGH_Z, COUNTER_HOLD}, ctl[i]);
		end
		host.send(w6(0, 1, 1, 3'h5, 0, 0, 1, 2'h3));
		chk({BLEED_LEVEL, MAIN_OUT_ON, AUX_OUT_ON, BLEED_ON, NEGATIVE_BLEED_ON}, 12'ha50);
		host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h0));
		chk({MAIN_OUT_ON, AUX_OUT_ON, BLEED_ON, NEGATIVE_BLEED_ON, PFD_POLARITY}, 5'h1e);
		chk({FEEDBACK_SELECT, OUTPUT_DIVIDER_SEL, BLEED_LEVEL, MAIN_OUT_POWER}, 14'h3697);
		host.send(w6(0, 0, 0, 3'h5, 0, 1, 0, 2'h1));
		chk({MAIN_OUT_ON, AUX_OUT_ON, FEEDBACK_SELECT, MAIN_OUT_POWER}, 5'h01);
		host.send(32'hffff_fff5);
		host.send(32'hffff_fff3);
		chk({PUMP_CURRENT_CODE, FEEDBACK_SELECT, MAIN_OUT_POWER}, 7'h51);
		$display("test field decode done");
		host.send(w4(0, 0, 10'h1, 1, 4'ha, 4'h0));
		host.send(w6(0, 0, 0, 3'h3, 0, 0, 1, 2'h1));
		chk(OUTPUT_DIVIDER_SEL, 3'h5);
		host.send(32'h0000_0000);
		chk(OUTPUT_DIVIDER_SEL, 3'h3);
		host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h0));
		host.send(w6(0, 0, 0, 3'h6, 0, 0, 1, 2'h1));
		chk(OUTPUT_DIVIDER_SEL, 3'h6);
		$display("test double buffer done");
		host.ref_run = 1'b1;
		for (i = 0; i < 6; i++) begin
			host.send(w4(dbl[i], hlf[i], rr[i], 0, 4'ha, (i == 5) ? 4'h1 : 4'h0));
			ticks(480);
			chk(n >= ex[i] - 1 && n <= ex[i] + 1, 1'b1);
			chk(m >= ex[i] - 1 && m <= ex[i] + 1, 1'b1);
		end
		$display("test reference path done");
		for (i = 0; i < 2; i++) begin
			host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h1));
			host.send(w7(0, i[1:0], 0, 2'h0, 0));
			host.send(w6(1, 0, 0, 3'h6, 1, 0, 1, 2'h1));
			chk({BLEED_ON, MAIN_OUT_ON, AUX_OUT_ON, LOCK_DETECT}, 4'h0);
			host.send(w4(0, 0, 10'h1, 0, 4'ha, 4'h0));
			c = 0;
			n = 0;
			while (LOCK_DETECT !== 1'b1) begin
				@(posedge CLOCK);
				#1;
				if (PHASE_DETECTOR_TICK === 1'b1) n++;
				c++;
				if (c > 5000) hang;
			end
			chk(n >= (64 << i) - 2 && n <= (64 << i) + 1, 1'b1);
			repeat (2) @(posedge CLOCK);
			#1;
			chk({BLEED_ON, MAIN_OUT_ON, AUX_OUT_ON}, 3'h7);
			PHASE_ERROR_PS = 16'h4e20;
			ticks(24);
			chk(LOCK_DETECT, 1'b0);
			PHASE_ERROR_PS = 16'h0064;
		end
		$display("test lock detect done");
		for (i = 0; i < 5; i++) begin
			host.send(w7(0, 2'h0, i[0], i[1:0], i == 4));
			chk({REF_LOSS_MODE, LOCK_WINDOW_PS}, {i[0], win[i]});
		end
		$display("test lock window done");
		host.send(w7(1, 2'h0, 0, 2'h0, 0));
		host.ref_run = 1'b0;
		repeat (3) @(posedge CLOCK);
		host.send(w4(0, 0, 10'h1, 0, 4'h3, 4'h0));
		repeat (20) @(posedge CLOCK);
		#1;
		chk(PUMP_CURRENT_CODE, 4'ha);
		host.ref_run = 1'b1;
		c = 0;
		while (LOAD_EVENT !== 1'b1) begin
			@(posedge CLOCK);
			#1;
			c++;
			if (c > 40) hang;
		end
		@(posedge CLOCK);
		#1;
		chk(PUMP_CURRENT_CODE, 4'h3);
		$display("test load sync done");
		test_done;
	end
	// watchdog against a stuck run
	initial begin
		repeat (60000) @(posedge CLOCK);
		hang;
	end
endmodule
